// ==== qpm_pkg.sv ====
// Package with constants for the quad serial-port pin mode select block
package qpm_pkg;

    // ****************************************************************
    // Mode straps
    // ****************************************************************
    localparam logic [2:0] MODE_STANDALONE = 3'h7;
    localparam logic [2:0] MODE_MINI_A     = 3'h1;
    localparam logic [2:0] MODE_MINI_B     = 3'h3;

    // ****************************************************************
    // Register space
    // ****************************************************************
    localparam int NUM_CH       = 4;
    localparam int ADDR_W       = 5;
    localparam int REG_IDX_W    = 3;
    localparam int CH_IDX_W     = 2;
    localparam logic [2:0] REG_FIFO_CTRL_IDX  = 3'h2;
    localparam logic [2:0] REG_LINE_CTRL_IDX  = 3'h3;
    localparam logic [2:0] REG_MODEM_CTRL_IDX = 3'h4;
    localparam logic [2:0] REG_MSR_IDX = 3'h6;
    localparam logic [2:0] REG_SCR_IDX = 3'h7;
    localparam logic [2:0] REG_EFR_IDX = 3'h5;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int FIFO_CTRL_DEEP_BIT  = 5;
    localparam int LINE_CTRL_DLAB_BIT  = 7;
    localparam int MODEM_CTRL_IRDA_BIT = 6;
    localparam int EFR_ENH_BIT         = 4;
    localparam int MSR_CARRIER_BIT     = 7;
    localparam int MSR_CARRIER_CHG_BIT = 3;
    localparam int STS_FSEL_BIT   = 0;
    localparam int STS_DEEP_BIT   = 1;

    // ****************************************************************
    // FIFO depths and reset values
    // ****************************************************************
    localparam int FIFO_DEPTH_STD  = 16;
    localparam int FIFO_DEPTH_DEEP = 128;
    localparam logic [7:0] REG_RST = 8'h00;

    // Access kind on the local processor port
    typedef enum logic [1:0] {
        QPM_ACC_IDLE,
        QPM_ACC_READ,
        QPM_ACC_WRITE
    } qpm_acc_t;

endpackage

// ==== qpm_reg_if.sv ====
// Interface joining the top to the per-channel register memory
`timescale 1ns/1ps
interface qpm_reg_if;
    logic       we;
    logic [4:0] waddr;
    logic [7:0] wdata;
    logic [4:0] raddr;
    logic [7:0] rdata;

    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ==== qpm_reg_mem.sv ====
// Small register memory holding channel registers, registered read data
`timescale 1ns/1ps
module qpm_reg_mem #(
    parameter int DEPTH = 32
) (
    input  wire logic  i_clk,
    input  wire logic  i_rst_n,
    qpm_reg_if.mem     bus
);
    logic [7:0] mem_ff     [DEPTH];
    logic [7:0] nxt_mem    [DEPTH];
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    always_comb begin
        nxt_mem   = mem_ff;
        nxt_rdata = mem_ff[bus.raddr];
        if (bus.we) begin
            nxt_mem[bus.waddr] = bus.wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= qpm_pkg::REG_RST;
            end
            rdata_ff <= qpm_pkg::REG_RST;
        end else begin
            mem_ff   <= nxt_mem;
            rdata_ff <= nxt_rdata;
        end
    end

    assign bus.rdata = rdata_ff;
endmodule // qpm_reg_mem

// ==== qpm_pin_mode.sv ====
// Mode-dependent pin function logic for the quad serial-port device
// Operation
// - Straps 111 select standalone processor port
// - Standalone mode ignores all PCI inputs
// - Pin one: open-drain INTA, standalone driven interrupt
// - Pin two: INTB, or CLKRUN in mini modes; released in standalone
// - FIFO depth 16 pin low, 128 high
// - Software reads live depth-select pin level
// - Deep write with latch bit, or enhanced: 128
// - Modem control bit6 in enhanced: infrared transmit
// - Infrared enabled: decode receive as infrared
// - Carrier detect low means carrier present
`timescale 1ns/1ps
module qpm_pin_mode #(
    parameter int NUM_CH = 4
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic [2:0]        i_mode,
    input  wire logic              i_fifo_depth_select_pin,
    input  wire logic              i_cs_n,
    input  wire logic              i_rd_n,
    input  wire logic              i_wr_n,
    input  wire logic [4:0]        i_addr,
    input  wire logic [7:0]        i_data,
    input  wire logic [NUM_CH-1:0] i_uart_int,
    input  wire logic              i_pci_inta_req,
    input  wire logic              i_pci_intb_req,
    input  wire logic              i_clkrun_req,
    input  wire logic              i_clkrun_pin,
    input  wire logic              i_pci_frame_n,
    input  wire logic              i_pci_irdy_n,
    input  wire logic              i_pci_idsel,
    input  wire logic [NUM_CH-1:0] i_serial_tx,
    input  wire logic [NUM_CH-1:0] i_irda_tx,
    input  wire logic [NUM_CH-1:0] i_serial_rx_pin,
    input  wire logic [NUM_CH-1:0] i_carrier_detect_n,
    output logic [7:0]             o_data,
    output logic                   o_data_oe_n,
    output logic                   o_rd_data_ctrl,
    output logic                   o_int1_out,
    output logic                   o_int1_oe_n,
    output logic                   o_int2_out,
    output logic                   o_int2_oe_n,
    output logic                   o_standalone,
    output logic                   o_pci_frame_n,
    output logic                   o_pci_irdy_n,
    output logic                   o_pci_idsel,
    output logic                   o_clkrun_n,
    output logic [7:0]             o_fifo_depth,
    output logic                   o_fsel_level,
    output logic [NUM_CH-1:0]      o_serial_tx_pin,
    output logic [NUM_CH-1:0]      o_rx_plain,
    output logic [NUM_CH-1:0]      o_rx_irda,
    output logic [NUM_CH-1:0]      o_carrier_present
);

    // ****************************************************************
    // Register memory
    // ****************************************************************
    qpm_reg_if rif ();

    qpm_reg_mem #(
        .DEPTH (NUM_CH * 8)
    ) u_mem (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .bus     (rif)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************

    function automatic logic is_mini(input logic [2:0] m);
        is_mini = (m == qpm_pkg::MODE_MINI_A) || (m == qpm_pkg::MODE_MINI_B);
    endfunction

    function automatic logic [1:0] ch_of(input logic [4:0] a);
        ch_of = a[qpm_pkg::ADDR_W-1:qpm_pkg::REG_IDX_W];
    endfunction

    // ****************************************************************
    // Access decode
    // ****************************************************************
    logic                 standalone;
    qpm_pkg::qpm_acc_t    acc;
    qpm_pkg::qpm_acc_t    acc_ff;
    qpm_pkg::qpm_acc_t    nxt_acc;

    assign standalone = (i_mode == qpm_pkg::MODE_STANDALONE);

    // Read wins when both strobes are low
    always_comb begin
        acc = qpm_pkg::QPM_ACC_IDLE;
        if (standalone && !i_cs_n && !i_rd_n) begin
            acc = qpm_pkg::QPM_ACC_READ;
        end else if (standalone && !i_cs_n && !i_wr_n) begin
            acc = qpm_pkg::QPM_ACC_WRITE;
        end
    end

    // Write only on the first cycle of the strobe
    assign rif.we    = (acc == qpm_pkg::QPM_ACC_WRITE) && (acc_ff != qpm_pkg::QPM_ACC_WRITE);
    assign rif.waddr = i_addr;
    assign rif.wdata = i_data;
    assign rif.raddr = i_addr;

    // ****************************************************************
    // Per-channel shadow control bits
    // ****************************************************************
    logic [NUM_CH-1:0] dlab_ff,  nxt_dlab;
    logic [NUM_CH-1:0] deep_ff,  nxt_deep;
    logic [NUM_CH-1:0] irda_ff,  nxt_irda;
    logic [NUM_CH-1:0] enh_ff,   nxt_enh;

    always_comb begin
        logic [1:0] ch;
        logic [2:0] ri;
        ch       = ch_of(i_addr);
        ri       = i_addr[qpm_pkg::REG_IDX_W-1:0];
        nxt_dlab = dlab_ff;
        nxt_deep = deep_ff;
        nxt_irda = irda_ff;
        nxt_enh  = enh_ff;
        if (rif.we) begin
            unique case (ri)
                qpm_pkg::REG_LINE_CTRL_IDX: nxt_dlab[ch] = i_data[qpm_pkg::LINE_CTRL_DLAB_BIT];
                qpm_pkg::REG_FIFO_CTRL_IDX: begin
                    if (dlab_ff[ch]) begin
                        nxt_deep[ch] = i_data[qpm_pkg::FIFO_CTRL_DEEP_BIT];
                    end
                end
                qpm_pkg::REG_MODEM_CTRL_IDX: nxt_irda[ch] = i_data[qpm_pkg::MODEM_CTRL_IRDA_BIT];
                qpm_pkg::REG_EFR_IDX: nxt_enh[ch]  = i_data[qpm_pkg::EFR_ENH_BIT];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Shadow bit registers
    // ****************************************************************

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dlab_ff <= '0;
            deep_ff <= '0;
            irda_ff <= '0;
            enh_ff  <= '0;
            acc_ff  <= qpm_pkg::QPM_ACC_IDLE;
        end else begin
            dlab_ff <= nxt_dlab;
            deep_ff <= nxt_deep;
            irda_ff <= nxt_irda;
            enh_ff  <= nxt_enh;
            acc_ff  <= nxt_acc;
        end
    end

    assign nxt_acc = acc;

    // ****************************************************************
    // Output stage
    // ****************************************************************
    logic [7:0]        data_ff,    nxt_data;
    logic              doe_ff,     nxt_doe;
    logic              rdc_ff,     nxt_rdc;
    logic              i1o_ff,     nxt_i1o;
    logic              i1e_ff,     nxt_i1e;
    logic              i2o_ff,     nxt_i2o;
    logic              i2e_ff,     nxt_i2e;
    logic              sa_ff,      nxt_sa;
    logic              frm_ff,     nxt_frm;
    logic              irdy_ff,    nxt_irdy;
    logic              idsel_ff,   nxt_idsel;
    logic              ckr_ff,     nxt_ckr;
    logic [7:0]        depth_ff,   nxt_depth;
    logic              fsel_ff,    nxt_fsel;
    logic [NUM_CH-1:0] tx_ff,      nxt_tx;
    logic [NUM_CH-1:0] rxp_ff,     nxt_rxp;
    logic [NUM_CH-1:0] rxi_ff,     nxt_rxi;
    logic [NUM_CH-1:0] cd_ff,      nxt_cd;

    always_comb begin
        logic [1:0] ch;
        logic [2:0] ri;
        logic       deep_any;
        logic [NUM_CH-1:0] irda_on;
        ch       = ch_of(i_addr);
        ri       = i_addr[qpm_pkg::REG_IDX_W-1:0];
        irda_on  = irda_ff & enh_ff;
        deep_any = i_fifo_depth_select_pin || (|deep_ff) || (|enh_ff);
        nxt_sa   = standalone;
        // Read data: live pin level and carrier in synthetic bits
        nxt_rdc  = (acc == qpm_pkg::QPM_ACC_READ);
        nxt_doe  = !(acc == qpm_pkg::QPM_ACC_READ);
        nxt_data = rif.rdata;
        if (ri == qpm_pkg::REG_SCR_IDX) begin
            nxt_data = '0;
            nxt_data[qpm_pkg::STS_FSEL_BIT] = i_fifo_depth_select_pin;
            nxt_data[qpm_pkg::STS_DEEP_BIT] = deep_any;
        end else if (ri == qpm_pkg::REG_MSR_IDX) begin
            nxt_data = '0;
            nxt_data[qpm_pkg::MSR_CARRIER_BIT] = !i_carrier_detect_n[ch];
        end
        // Interrupt pin one
        if (standalone) begin
            nxt_i1o = |i_uart_int;
            nxt_i1e = 1'b0;
        end else begin
            nxt_i1o = 1'b0;
            nxt_i1e = !i_pci_inta_req;
        end
        // Interrupt pin two
        nxt_i2o = 1'b0;
        if (is_mini(i_mode)) begin
            nxt_i2e = !i_clkrun_req;
        end else if (standalone) begin
            nxt_i2e = 1'b1;
        end else begin
            nxt_i2e = !i_pci_intb_req;
        end
        nxt_ckr   = is_mini(i_mode) ? i_clkrun_pin : 1'b1;
        // PCI inputs forced inactive in standalone
        nxt_frm   = standalone ? 1'b1 : i_pci_frame_n;
        nxt_irdy  = standalone ? 1'b1 : i_pci_irdy_n;
        nxt_idsel = standalone ? 1'b0 : i_pci_idsel;
        nxt_depth = deep_any ? 8'(qpm_pkg::FIFO_DEPTH_DEEP) : 8'(qpm_pkg::FIFO_DEPTH_STD);
        nxt_fsel  = i_fifo_depth_select_pin;
        nxt_tx    = (irda_on & i_irda_tx) | (~irda_on & i_serial_tx);
        nxt_rxi   = irda_on & i_serial_rx_pin;
        nxt_rxp   = ~irda_on & i_serial_rx_pin | irda_on;
        nxt_cd    = ~i_carrier_detect_n;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            data_ff  <= '0;
            doe_ff   <= 1'b1;
            rdc_ff   <= 1'b0;
            i1o_ff   <= 1'b0;
            i1e_ff   <= 1'b1;
            i2o_ff   <= 1'b0;
            i2e_ff   <= 1'b1;
            sa_ff    <= 1'b0;
            frm_ff   <= 1'b1;
            irdy_ff  <= 1'b1;
            idsel_ff <= 1'b0;
            ckr_ff   <= 1'b1;
            depth_ff <= 8'(qpm_pkg::FIFO_DEPTH_STD);
            fsel_ff  <= 1'b0;
            tx_ff    <= '1;
            rxp_ff   <= '1;
            rxi_ff   <= '0;
            cd_ff    <= '0;
        end else begin
            data_ff  <= nxt_data;
            doe_ff   <= nxt_doe;
            rdc_ff   <= nxt_rdc;
            i1o_ff   <= nxt_i1o;
            i1e_ff   <= nxt_i1e;
            i2o_ff   <= nxt_i2o;
            i2e_ff   <= nxt_i2e;
            sa_ff    <= nxt_sa;
            frm_ff   <= nxt_frm;
            irdy_ff  <= nxt_irdy;
            idsel_ff <= nxt_idsel;
            ckr_ff   <= nxt_ckr;
            depth_ff <= nxt_depth;
            fsel_ff  <= nxt_fsel;
            tx_ff    <= nxt_tx;
            rxp_ff   <= nxt_rxp;
            rxi_ff   <= nxt_rxi;
            cd_ff    <= nxt_cd;
        end
    end

    // ****************************************************************
    // Pin drivers
    // ****************************************************************

    assign o_data            = data_ff;
    assign o_data_oe_n       = doe_ff;
    assign o_rd_data_ctrl    = rdc_ff;
    assign o_int1_out        = i1o_ff;
    assign o_int1_oe_n       = i1e_ff;
    assign o_int2_out        = i2o_ff;
    assign o_int2_oe_n       = i2e_ff;
    assign o_standalone      = sa_ff;
    assign o_pci_frame_n     = frm_ff;
    assign o_pci_irdy_n      = irdy_ff;
    assign o_pci_idsel       = idsel_ff;
    assign o_clkrun_n        = ckr_ff;
    assign o_fifo_depth      = depth_ff;
    assign o_fsel_level      = fsel_ff;
    assign o_serial_tx_pin   = tx_ff;
    assign o_rx_plain        = rxp_ff;
    assign o_rx_irda         = rxi_ff;
    assign o_carrier_present = cd_ff;

endmodule // qpm_pin_mode

// ==== qpm_pin_mode_properties.sv ====
// Port assertions for the pin mode block
`timescale 1ns/1ps
module qpm_pin_mode_checker #(
    parameter int NUM_CH = 4
) (
    input wire logic              i_clk,
    input wire logic              i_rst_n,
    input wire logic [2:0]        i_mode,
    input wire logic              i_fifo_depth_select_pin,
    input wire logic              i_cs_n,
    input wire logic              i_rd_n,
    input wire logic              i_pci_inta_req,
    input wire logic              i_pci_intb_req,
    input wire logic              i_clkrun_pin,
    input wire logic [NUM_CH-1:0] i_carrier_detect_n,
    input wire logic              o_data_oe_n,
    input wire logic              o_rd_data_ctrl,
    input wire logic              o_int1_oe_n,
    input wire logic              o_int2_oe_n,
    input wire logic              o_standalone,
    input wire logic              o_pci_frame_n,
    input wire logic              o_pci_irdy_n,
    input wire logic              o_pci_idsel,
    input wire logic              o_clkrun_n,
    input wire logic [7:0]        o_fifo_depth,
    input wire logic              o_fsel_level,
    input wire logic [NUM_CH-1:0] o_carrier_present
);
    localparam logic [2:0] SA = qpm_pkg::MODE_STANDALONE;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    strap_decode_a: assert property (1 |=> o_standalone == ($past(i_mode) == SA))
        else $error("standalone flag does not follow straps");
    pci_gated_a: assert property ((i_mode == SA) |=> o_pci_frame_n && o_pci_irdy_n && !o_pci_idsel)
        else $error("pci inputs pass in standalone");
    int1_driven_a: assert property ((i_mode == SA) |=> !o_int1_oe_n)
        else $error("interrupt one not driven in standalone");
    int1_released_a: assert property ((i_mode != SA && !i_pci_inta_req) |=> o_int1_oe_n)
        else $error("interrupt one pulled without request");
    clkrun_a: assert property ((i_mode == qpm_pkg::MODE_MINI_A || i_mode == qpm_pkg::MODE_MINI_B)
        |=> o_clkrun_n == $past(i_clkrun_pin))
        else $error("clock run level not followed");
    intb_pull_a: assert property ((i_mode == 3'h0 && i_pci_intb_req) |=> !o_int2_oe_n)
        else $error("interrupt two not pulled");
    depth_pin_a: assert property (i_fifo_depth_select_pin |=> o_fifo_depth == 8'h80)
        else $error("deep fifo not selected by pin");
    depth_value_a: assert property (o_fifo_depth == 8'h10 || o_fifo_depth == 8'h80)
        else $error("illegal fifo depth");
    fsel_live_a: assert property (1 |=> o_fsel_level == $past(i_fifo_depth_select_pin))
        else $error("pin level not reported");
    carrier_a: assert property (1 |=> o_carrier_present == ~$past(i_carrier_detect_n))
        else $error("carrier present wrong");
    read_ctrl_a: assert property ((i_mode == SA && !i_cs_n && !i_rd_n) |=> o_rd_data_ctrl && !o_data_oe_n)
        else $error("read not answered");
    no_read_a: assert property ((i_mode != SA) |=> !o_rd_data_ctrl && o_data_oe_n)
        else $error("data driven outside standalone");
endmodule // qpm_pin_mode_checker

// ==== qpm_cpu_model.sv ====
// Standalone processor model on the local register port
`timescale 1ns/1ps
module qpm_cpu_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_data,
    input  wire logic       i_rd_data_ctrl,
    output logic            o_cs_n,
    output logic            o_rd_n,
    output logic            o_wr_n,
    output logic [4:0]      o_addr,
    output logic [7:0]      o_data
);
    initial begin
        {o_cs_n, o_rd_n, o_wr_n} = 3'h7;
        o_addr = 5'h00;
        o_data = 8'h00;
    end

    // Strobe one edge, then one idle cycle; released lines invert
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        {o_cs_n, o_wr_n, o_addr, o_data} <= {2'b00, a, d};
        @(posedge i_clk);
        {o_cs_n, o_wr_n, o_addr, o_data} <= {2'b11, ~a, ~d};
        @(posedge i_clk);
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] d, output bit ok);
        ok = 1'b0;
        {o_cs_n, o_rd_n, o_addr} <= {2'b00, a};
        for (int n = 0; n < 8 && !ok; n++) begin
            @(posedge i_clk);
            ok = (i_rd_data_ctrl === 1'b1);
        end
        @(posedge i_clk);
        d = i_data;
        {o_cs_n, o_rd_n, o_addr} <= {2'b11, ~a};
        @(posedge i_clk);
    endtask
endmodule // qpm_cpu_model

// ==== tb_qpm_pin_mode.sv ====
// Self-checking bench for the pin mode block
`timescale 1ns/1ps
module tb_qpm_pin_mode;
    logic       i_clk, i_rst_n, i_fifo_depth_select_pin, i_cs_n, i_rd_n, i_wr_n;
    logic       i_pci_inta_req, i_pci_intb_req, i_clkrun_req, i_clkrun_pin;
    logic       i_pci_frame_n, i_pci_irdy_n, i_pci_idsel;
    logic [2:0] i_mode;
    logic [4:0] i_addr;
    logic [7:0] i_data, o_data, o_fifo_depth;
    logic [3:0] i_uart_int, i_serial_tx, i_irda_tx, i_serial_rx_pin, i_carrier_detect_n;
    logic       o_data_oe_n, o_rd_data_ctrl, o_int1_out, o_int1_oe_n, o_int2_out, o_int2_oe_n;
    logic       o_standalone, o_pci_frame_n, o_pci_irdy_n, o_pci_idsel, o_clkrun_n, o_fsel_level;
    logic [3:0] o_serial_tx_pin, o_rx_plain, o_rx_irda, o_carrier_present;
    int         fails, n_checks;

    qpm_pin_mode uut (
        .i_clk, .i_rst_n, .i_mode, .i_fifo_depth_select_pin, .i_cs_n, .i_rd_n, .i_wr_n, .i_addr,
        .i_data, .i_uart_int, .i_pci_inta_req, .i_pci_intb_req, .i_clkrun_req, .i_clkrun_pin,
        .i_pci_frame_n, .i_pci_irdy_n, .i_pci_idsel, .i_serial_tx, .i_irda_tx, .i_serial_rx_pin,
        .i_carrier_detect_n, .o_data, .o_data_oe_n, .o_rd_data_ctrl, .o_int1_out, .o_int1_oe_n,
        .o_int2_out, .o_int2_oe_n, .o_standalone, .o_pci_frame_n, .o_pci_irdy_n, .o_pci_idsel,
        .o_clkrun_n, .o_fifo_depth, .o_fsel_level, .o_serial_tx_pin, .o_rx_plain, .o_rx_irda,
        .o_carrier_present
    );
    qpm_cpu_model cpu (
        .i_clk, .i_data(o_data), .i_rd_data_ctrl(o_rd_data_ctrl), .o_cs_n(i_cs_n),
        .o_rd_n(i_rd_n), .o_wr_n(i_wr_n), .o_addr(i_addr), .o_data(i_data)
    );

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        if (fails == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic settle();
        repeat (2) @(posedge i_clk);
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        bit ok;
        cpu.rd(a, d, ok);
        if (!ok) begin
            fails++;
            summarize();
        end
    endtask

    task automatic t_modes();
        bit sa, mini;
        logic [2:0] mv;
        for (int m = 0; m < 8; m++) begin
            mv = 3'(m);
            sa = (mv == 3'h7);
            mini = (mv == 3'h1 || mv == 3'h3);
            {i_mode, i_clkrun_pin, i_pci_inta_req, i_pci_frame_n, i_clkrun_req} <= {mv, mv[1], mv[1], mv[0], mv[1]};
            settle();
            chk("standalone", 8'(o_standalone), 8'(sa));
            chk("pci frame", 8'(o_pci_frame_n), 8'(sa | mv[0]));
            chk("pci irdy", 8'(o_pci_irdy_n), 8'(sa));
            chk("pci idsel", 8'(o_pci_idsel), 8'(!sa));
            chk("int1 oe", 8'(o_int1_oe_n), 8'(!sa && !mv[1]));
            chk("clkrun", 8'(o_clkrun_n), 8'(mini ? mv[1] : 1'b1));
            chk("int1 out", 8'(o_int1_out), 8'(sa));
            chk("int2 out", 8'(o_int2_out), 8'h00);
            if (!sa) begin
                chk("int2 oe", 8'(o_int2_oe_n), 8'(mini && !mv[1]));
            end
        end
    endtask

    task automatic t_depth();
        logic [7:0] d;
        for (int p = 0; p < 2; p++) begin
            i_fifo_depth_select_pin <= 1'(p);
            settle();
            chk("depth", o_fifo_depth, (p == 1) ? 8'h80 : 8'h10);
            chk("fsel level", 8'(o_fsel_level), 8'(p));
            rd(5'h07, d);
            chk("pin status", d & 8'h01, 8'(p));
        end
        i_fifo_depth_select_pin <= 1'b0;
        settle();
    endtask

    task automatic t_regs();
        logic [7:0] d;
        i_mode <= 3'h0;
        @(posedge i_clk);
        cpu.wr({2'h1, qpm_pkg::REG_LINE_CTRL_IDX}, 8'h5a);
        i_mode <= qpm_pkg::MODE_STANDALONE;
        @(posedge i_clk);
        rd({2'h1, qpm_pkg::REG_LINE_CTRL_IDX}, d);
        chk("refused write", d, 8'h00);
        for (int c = 0; c < 4; c++) cpu.wr({2'(c), qpm_pkg::REG_LINE_CTRL_IDX}, 8'(8'h31 + c));
        for (int c = 0; c < 4; c++) begin
            rd({2'(c), qpm_pkg::REG_LINE_CTRL_IDX}, d);
            chk("line ctrl readback", d, 8'(8'h31 + c));
        end
        cpu.wr({2'h1, qpm_pkg::REG_FIFO_CTRL_IDX}, 8'h20);
        settle();
        chk("depth unlatched", o_fifo_depth, 8'h10);
        cpu.wr({2'h1, qpm_pkg::REG_LINE_CTRL_IDX}, 8'h80);
        cpu.wr({2'h1, qpm_pkg::REG_FIFO_CTRL_IDX}, 8'h20);
        settle();
        chk("depth latched", o_fifo_depth, 8'h80);
        rd(5'h0f, d);
        chk("deep status", d & 8'h02, 8'h02);
    endtask

    task automatic t_ir();
        i_rst_n <= 1'b0;
        settle();
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        chk("depth after reset", o_fifo_depth, 8'h10);
        {i_serial_tx, i_irda_tx, i_serial_rx_pin} <= {4'b1010, 4'b0101, 4'b0110};
        cpu.wr({2'h3, qpm_pkg::REG_MODEM_CTRL_IDX}, 8'h40);
        settle();
        chk("tx plain", 8'(o_serial_tx_pin), 8'h0a);
        cpu.wr({2'h2, qpm_pkg::REG_EFR_IDX}, 8'h10);
        cpu.wr({2'h2, qpm_pkg::REG_MODEM_CTRL_IDX}, 8'h40);
        cpu.wr({2'h3, qpm_pkg::REG_MODEM_CTRL_IDX}, 8'h00);
        settle();
        chk("enhanced depth", o_fifo_depth, 8'h80);
        chk("tx infrared", 8'(o_serial_tx_pin), 8'h0e);
        chk("rx infrared", 8'(o_rx_irda), 8'h04);
        i_serial_rx_pin <= 4'b1011;
        settle();
        chk("rx infrared low", 8'(o_rx_irda), 8'h00);
        chk("rx plain", 8'(o_rx_plain), 8'h0f);
    endtask

    task automatic t_carrier();
        logic [7:0] d;
        i_carrier_detect_n <= 4'b1001;
        settle();
        chk("carrier", 8'(o_carrier_present), 8'h06);
        rd({2'h1, qpm_pkg::REG_MSR_IDX}, d);
        chk("status carrier ch1", d & 8'h80, 8'h80);
        rd({2'h3, qpm_pkg::REG_MSR_IDX}, d);
        chk("status carrier ch3", d & 8'h80, 8'h00);
    endtask

    initial begin
        fails = 0;
        n_checks = 0;
        {i_rst_n, i_mode, i_fifo_depth_select_pin} = 5'h00;
        {i_pci_inta_req, i_pci_intb_req, i_clkrun_req, i_clkrun_pin} = 4'b0100;
        {i_pci_frame_n, i_pci_irdy_n, i_pci_idsel} = 3'b001;
        {i_uart_int, i_serial_tx, i_irda_tx} = 12'h200;
        {i_serial_rx_pin, i_carrier_detect_n} = 8'hff;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        t_modes();
        t_depth();
        t_regs();
        t_ir();
        t_carrier();
        summarize();
    end
endmodule // tb_qpm_pin_mode

bind qpm_pin_mode qpm_pin_mode_checker #(.NUM_CH(NUM_CH)) props (
    .i_clk, .i_rst_n, .i_mode, .i_fifo_depth_select_pin, .i_cs_n, .i_rd_n, .i_pci_inta_req,
    .i_pci_intb_req, .i_clkrun_pin, .i_carrier_detect_n, .o_data_oe_n, .o_rd_data_ctrl,
    .o_int1_oe_n, .o_int2_oe_n, .o_standalone, .o_pci_frame_n, .o_pci_irdy_n, .o_pci_idsel,
    .o_clkrun_n, .o_fifo_depth, .o_fsel_level, .o_carrier_present
);
